// ### core/ata_cmd_pkg.sv
// package: task-file layout, command codes, reset values and timing for the command block
// Overview of operation
// - opcode EFH, Feature register selects setting
// - 01H: low byte lane, no IOCS16
// - 81H: back to 16-bit data
// - 02H/82H cache on/off, flush first on 82H only
// - 03H: count bits 7:3 type, 2:0 mode
// - type 0: mode 0 default, 1 no IORDY
// - PIO flow, MDMA, UDMA; rest reserved
// - one PIO mode always selected
// - 05H/85H advanced power management on/off
// - 09H/89H extended power operations on/off
// - 55H look-ahead off (default), AAH on
// - 66H/CCH control defaults at software reset
// - 69H, 96H, 97H complete, change nothing
// - idle opcodes: busy, idle, interrupt
// - nonzero count loads a timeout of count x 5 ms units
// - zero count uses three 5 ms units
// - sleep opcodes: busy, sleep, interrupt
// - any further command wakes from sleep
// - inactivity timer expiry enters sleep, 15 ms
// - 8BH needs exact signature, else invalid
// - AAH write protect, 55H power-down input
// - pin mode survives reset, nonvolatile
package ata_cmd_pkg;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] feature;
    logic [7:0] sec_cnt;
    logic [7:0] sec_num;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] dev_head;
  } taskfile_t;

  typedef struct packed {
    logic eight_bit;
    logic wcache;
    logic apm;
    logic ext_pwr;
    logic lookahead;
    logic por_restore;
    logic iordy_dis;
    logic pio_flow;
    logic [2:0] pio_mode;
    logic [1:0] dma_kind;
    logic [2:0] dma_mode;
  } cfg_t;

  typedef enum logic [1:0] {PWR_ACTIVE = 2'b00, PWR_IDLE = 2'b01, PWR_SLEEP = 2'b10} pwr_t;
  typedef enum logic [2:0] {
    ST_READY = 3'b000, ST_EXEC = 3'b001, ST_FLUSH = 3'b010, ST_NVWR = 3'b011, ST_DONE = 3'b100
  } cmd_st_t;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OP_SET_FEAT = 8'hef;
  localparam logic [7:0] OP_IDLE_A = 8'h97;
  localparam logic [7:0] OP_IDLE_B = 8'he3;
  localparam logic [7:0] OP_SLEEP_A = 8'h99;
  localparam logic [7:0] OP_SLEEP_B = 8'he6;
  localparam logic [7:0] OP_PIN_MODE = 8'h8b;

  localparam logic [7:0] FT_8BIT_ON = 8'h01;
  localparam logic [7:0] FT_WCACHE_ON = 8'h02;
  localparam logic [7:0] FT_XFER = 8'h03;
  localparam logic [7:0] FT_APM_ON = 8'h05;
  localparam logic [7:0] FT_EXT_ON = 8'h09;
  localparam logic [7:0] FT_LA_OFF = 8'h55;
  localparam logic [7:0] FT_POR_OFF = 8'h66;
  localparam logic [7:0] FT_NOP_A = 8'h69;
  localparam logic [7:0] FT_8BIT_OFF = 8'h81;
  localparam logic [7:0] FT_WCACHE_OFF = 8'h82;
  localparam logic [7:0] FT_APM_OFF = 8'h85;
  localparam logic [7:0] FT_EXT_OFF = 8'h89;
  localparam logic [7:0] FT_NOP_B = 8'h96;
  localparam logic [7:0] FT_NOP_C = 8'h97;
  localparam logic [7:0] FT_LA_ON = 8'haa;
  localparam logic [7:0] FT_POR_ON = 8'hcc;

  localparam logic [7:0] PIN_SIG_CYL_HIGH = 8'h6e;
  localparam logic [7:0] PIN_SIG_CYL_LOW = 8'h44;
  localparam logic [7:0] PIN_SIG_SEC_NUM = 8'h72;
  localparam logic [7:0] PIN_SIG_SEC_CNT = 8'h50;
  localparam logic [7:0] PIN_FT_WP = 8'haa;
  localparam logic [7:0] PIN_FT_PD = 8'h55;
  localparam int DRIVE_BIT = 4;
  localparam logic PIN_WP = 1'b0;
  localparam logic PIN_PD = 1'b1;

  localparam logic [4:0] XT_PIO_DEF = 5'h00;
  localparam logic [4:0] XT_PIO_FLOW = 5'h01;
  localparam logic [4:0] XT_MDMA = 5'h04;
  localparam logic [4:0] XT_UDMA = 5'h08;
  localparam logic [2:0] XM_DEFAULT = 3'h0;
  localparam logic [2:0] XM_NO_IORDY = 3'h1;
  localparam logic [1:0] DMA_NONE = 2'h0;
  localparam logic [1:0] DMA_MULTI = 2'h1;
  localparam logic [1:0] DMA_ULTRA = 2'h2;

  localparam cfg_t CFG_DEFAULT = '{eight_bit: 1'b0, wcache: 1'b0, apm: 1'b0, ext_pwr: 1'b0,
                                   lookahead: 1'b0, por_restore: 1'b1, iordy_dis: 1'b0,
                                   pio_flow: 1'b0, pio_mode: XM_DEFAULT, dma_kind: DMA_NONE,
                                   dma_mode: 3'h0};

  ////////////////////////////////////////////////////////////////////////////////
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int UNIT_TIME_MS = 5;
  localparam int UNIT_CYCLES = UNIT_TIME_MS * CLK_FREQ_KHZ;
  localparam int INACT_TIME_MS = 15;
  localparam logic [7:0] INACT_UNITS = 8'(INACT_TIME_MS / UNIT_TIME_MS);
  localparam logic [7:0] IDLE_ZERO_UNITS = 8'h03;

  // transfer-mode code check for feature 03h
  function automatic logic xfer_valid(input logic [7:0] sc);
    case (sc[7:3])
      XT_PIO_DEF: xfer_valid = (sc[2:0] == XM_DEFAULT) || (sc[2:0] == XM_NO_IORDY);
      XT_PIO_FLOW, XT_MDMA, XT_UDMA: xfer_valid = 1'b1;
      default: xfer_valid = 1'b0;
    endcase
  endfunction

endpackage

// ### core/ata_feature_power_cmds.sv
// command handling for set-features, idle, sleep and pin-mode commands
`timescale 1ns/1ns
module ata_feature_power_cmds #(
  parameter int TICK_CYCLES = ata_cmd_pkg::UNIT_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // command issue
  input wire logic i_cmd_valid,
  input wire ata_cmd_pkg::taskfile_t i_tf,
  input wire logic i_soft_reset,
  input wire logic i_drive_num,
  // cache flush handshake
  input wire logic i_flush_done,
  output logic o_flush_req,
  // nonvolatile pin-mode storage
  input wire logic i_nv_mode,
  input wire logic i_nv_ack,
  output logic o_nv_wr_req,
  output logic o_nv_wr_mode,
  // status
  output logic o_busy,
  output logic o_irq,
  output logic o_abort,
  output ata_cmd_pkg::pwr_t o_pwr_state,
  output logic o_auto_pd_en,
  // configuration
  output ata_cmd_pkg::cfg_t o_cfg,
  output logic o_iocs16_en,
  output logic o_pin_powerdown
);
  import ata_cmd_pkg::*;

  cmd_st_t st_reg;
  taskfile_t tf_reg;
  logic [7:0] units_reg;
  logic cmd_taken;
  logic exec;
  logic is_feat;
  logic is_idle;
  logic is_sleep;
  logic is_pin;
  logic feat_ok;
  logic pin_sig_ok;
  logic bad_cmd;
  logic need_flush;
  logic pin_start;
  logic store_done;
  logic expire;
  logic [7:0] idle_units;
  logic [1:0] drive_sync_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the latched task file
  assign cmd_taken = i_cmd_valid && (st_reg == ST_READY);
  assign exec = (st_reg == ST_EXEC);

  // drive number is a strap pin from outside the clock domain, two flops before the compare
  always_ff @(posedge i_ref_clk) begin
    drive_sync_reg <= {drive_sync_reg[0], i_drive_num};
  end

  always_comb begin
    is_feat = (tf_reg.command == OP_SET_FEAT);
    is_idle = (tf_reg.command == OP_IDLE_A) || (tf_reg.command == OP_IDLE_B);
    is_sleep = (tf_reg.command == OP_SLEEP_A) || (tf_reg.command == OP_SLEEP_B);
    is_pin = (tf_reg.command == OP_PIN_MODE);
    pin_sig_ok = (tf_reg.cyl_high == PIN_SIG_CYL_HIGH) && (tf_reg.cyl_low == PIN_SIG_CYL_LOW) &&
                 (tf_reg.sec_num == PIN_SIG_SEC_NUM) && (tf_reg.sec_cnt == PIN_SIG_SEC_CNT) &&
                 (tf_reg.dev_head[DRIVE_BIT] == drive_sync_reg[1]) &&
                 ((tf_reg.feature == PIN_FT_WP) || (tf_reg.feature == PIN_FT_PD));
    case (tf_reg.feature)
      FT_8BIT_ON, FT_WCACHE_ON, FT_APM_ON, FT_EXT_ON, FT_LA_OFF, FT_POR_OFF, FT_NOP_A,
      FT_8BIT_OFF, FT_WCACHE_OFF, FT_APM_OFF, FT_EXT_OFF, FT_NOP_B, FT_NOP_C, FT_LA_ON,
      FT_POR_ON: feat_ok = 1'b1;
      FT_XFER: feat_ok = xfer_valid(tf_reg.sec_cnt);
      default: feat_ok = 1'b0;
    endcase
    bad_cmd = (is_feat && !feat_ok) || (is_pin && !pin_sig_ok);
    need_flush = is_feat && (tf_reg.feature == FT_WCACHE_OFF);
    pin_start = exec && is_pin && pin_sig_ok;
    idle_units = (tf_reg.sec_cnt == 8'h00) ? IDLE_ZERO_UNITS : tf_reg.sec_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command sequencer; new commands are taken only while not busy
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_reg <= ST_READY;
    end else begin
      case (st_reg)
        ST_READY: if (cmd_taken) st_reg <= ST_EXEC;
        ST_EXEC: begin
          if (need_flush) begin
            st_reg <= ST_FLUSH;
          end else if (pin_start) begin
            st_reg <= ST_NVWR;
          end else begin
            st_reg <= ST_DONE;
          end
        end
        ST_FLUSH: if (i_flush_done) st_reg <= ST_DONE;
        ST_NVWR: if (store_done) st_reg <= ST_DONE;
        ST_DONE: st_reg <= ST_READY;
        default: st_reg <= ST_READY;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      tf_reg <= '0;
    end else if (cmd_taken) begin
      tf_reg <= i_tf;
    end
  end

  // busy rises the cycle after a command is taken, falls with the interrupt
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_busy <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_irq <= (st_reg == ST_DONE);
      if (cmd_taken) begin
        o_busy <= 1'b1;
      end else if (st_reg == ST_DONE) begin
        o_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_abort <= 1'b0;
    end else if (cmd_taken) begin
      o_abort <= 1'b0;
    end else if (exec && bad_cmd) begin
      o_abort <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_flush_req <= 1'b0;
    end else if (exec && need_flush) begin
      o_flush_req <= 1'b1;
    end else if (i_flush_done) begin
      o_flush_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // feature configuration; soft reset restores only while idle so it cannot tear a command
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_cfg <= CFG_DEFAULT;
    end else if (exec && is_feat) begin
      case (tf_reg.feature)
        FT_8BIT_ON: o_cfg.eight_bit <= 1'b1;
        FT_8BIT_OFF: o_cfg.eight_bit <= 1'b0;
        FT_WCACHE_ON: o_cfg.wcache <= 1'b1;
        FT_WCACHE_OFF: o_cfg.wcache <= 1'b0;
        FT_APM_ON: o_cfg.apm <= 1'b1;
        FT_APM_OFF: o_cfg.apm <= 1'b0;
        FT_EXT_ON: o_cfg.ext_pwr <= 1'b1;
        FT_EXT_OFF: o_cfg.ext_pwr <= 1'b0;
        FT_LA_ON: o_cfg.lookahead <= 1'b1;
        FT_LA_OFF: o_cfg.lookahead <= 1'b0;
        FT_POR_ON: o_cfg.por_restore <= 1'b1;
        FT_POR_OFF: o_cfg.por_restore <= 1'b0;
        FT_XFER: begin
          // dma choice never touches the pio fields, so a pio mode stays selected
          case (tf_reg.sec_cnt[7:3])
            XT_PIO_DEF: begin
              if (xfer_valid(tf_reg.sec_cnt)) begin
                o_cfg.pio_flow <= 1'b0;
                o_cfg.pio_mode <= XM_DEFAULT;
                o_cfg.iordy_dis <= (tf_reg.sec_cnt[2:0] == XM_NO_IORDY);
              end
            end
            XT_PIO_FLOW: begin
              o_cfg.pio_flow <= 1'b1;
              o_cfg.pio_mode <= tf_reg.sec_cnt[2:0];
              o_cfg.iordy_dis <= 1'b0;
            end
            XT_MDMA: begin
              o_cfg.dma_kind <= DMA_MULTI;
              o_cfg.dma_mode <= tf_reg.sec_cnt[2:0];
            end
            XT_UDMA: begin
              o_cfg.dma_kind <= DMA_ULTRA;
              o_cfg.dma_mode <= tf_reg.sec_cnt[2:0];
            end
            default: o_cfg.dma_kind <= o_cfg.dma_kind;
          endcase
        end
        default: o_cfg <= o_cfg;
      endcase
    end else if (i_soft_reset && (st_reg == ST_READY) && o_cfg.por_restore) begin
      o_cfg <= CFG_DEFAULT;
    end
  end

  // one cycle behind the width setting
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_iocs16_en <= 1'b1;
    end else begin
      o_iocs16_en <= !o_cfg.eight_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power states and automatic power-down
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pwr_state <= PWR_ACTIVE;
    end else if (exec && is_idle) begin
      o_pwr_state <= PWR_IDLE;
    end else if (exec && is_sleep) begin
      o_pwr_state <= PWR_SLEEP;
    end else if (cmd_taken || i_soft_reset) begin
      o_pwr_state <= PWR_ACTIVE;
    end else if (expire && o_auto_pd_en && (st_reg == ST_READY)) begin
      o_pwr_state <= PWR_SLEEP;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      units_reg <= INACT_UNITS;
      o_auto_pd_en <= 1'b1;
    end else if (exec && is_idle) begin
      units_reg <= idle_units;
      o_auto_pd_en <= 1'b1;
    end
  end

  // restart on every executed command keeps the idle timeout measured from the last activity
  power_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_restart(exec),
    .i_units(is_idle ? idle_units : units_reg),
    .i_run((st_reg == ST_READY) && (o_pwr_state != PWR_SLEEP)),
    .o_expire(expire)
  );

  pin_mode_store u_store (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_start(pin_start),
    .i_mode(tf_reg.feature == PIN_FT_PD),
    .o_done(store_done),
    .i_nv_mode(i_nv_mode),
    .i_nv_ack(i_nv_ack),
    .o_nv_wr_req(o_nv_wr_req),
    .o_nv_wr_mode(o_nv_wr_mode),
    .o_mode(o_pin_powerdown)
  );

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_end_ok;
    ##1 (o_irq && !o_busy && !o_abort);
  endsequence
  sequence s_end_abort;
    ##1 (o_irq && !o_busy && o_abort);
  endsequence

  a_eight_bit_on: assert property (exec && is_feat && tf_reg.feature == FT_8BIT_ON |=>
    o_cfg.eight_bit ##1 !o_iocs16_en) else $error("8-bit mode not entered");
  a_eight_bit_off: assert property (exec && is_feat && tf_reg.feature == FT_8BIT_OFF |=>
    !o_cfg.eight_bit ##1 o_iocs16_en) else $error("8-bit mode not left");
  a_flush_first: assert property (exec && need_flush |=>
    o_flush_req && o_busy && !o_irq && !o_cfg.wcache) else $error("cache disable skipped flush");
  a_flush_no_irq: assert property (o_flush_req |-> !o_irq && o_busy)
    else $error("completion during flush");
  a_reserved_abort: assert property (exec && is_feat && tf_reg.feature == FT_XFER &&
    !xfer_valid(tf_reg.sec_cnt) |=> $stable(o_cfg) ##0 s_end_abort) else $error("reserved mode not aborted");
  a_pio_kept: assert property (exec && is_feat && tf_reg.feature == FT_XFER &&
    (tf_reg.sec_cnt[7:3] == XT_MDMA || tf_reg.sec_cnt[7:3] == XT_UDMA) |=>
    $stable(o_cfg.pio_mode) && $stable(o_cfg.pio_flow)) else $error("dma select disturbed pio mode");
  a_nop_stable: assert property (exec && is_feat && (tf_reg.feature == FT_NOP_A ||
    tf_reg.feature == FT_NOP_B || tf_reg.feature == FT_NOP_C) |=> $stable(o_cfg) ##0 s_end_ok)
    else $error("nop feature changed settings");
  a_idle_enter: assert property (exec && is_idle |=> o_pwr_state == PWR_IDLE && o_auto_pd_en
    ##0 s_end_ok) else $error("idle command not completed");
  a_idle_units: assert property (exec && is_idle |=>
    units_reg == (($past(tf_reg.sec_cnt) == 8'h00) ? 8'h03 : $past(tf_reg.sec_cnt)))
    else $error("idle timeout not loaded");
  a_sleep_enter: assert property (exec && is_sleep |=> o_pwr_state == PWR_SLEEP ##0 s_end_ok)
    else $error("sleep command not completed");
  a_wake: assert property (cmd_taken && o_pwr_state == PWR_SLEEP |=> o_pwr_state == PWR_ACTIVE)
    else $error("command did not wake device");
  a_auto_sleep: assert property (expire && o_auto_pd_en && st_reg == ST_READY && !cmd_taken &&
    !i_soft_reset |=> o_pwr_state == PWR_SLEEP) else $error("timer expiry did not sleep");
  a_pin_invalid: assert property (exec && is_pin && !pin_sig_ok |=>
    !o_nv_wr_req && $stable(o_pin_powerdown) ##0 s_end_abort) else $error("bad pin-mode signature accepted");
  a_pin_write: assert property (pin_start |=> o_nv_wr_req &&
    o_nv_wr_mode == ($past(tf_reg.feature) == PIN_FT_PD)) else $error("pin mode write wrong");
  a_por_restore: assert property (i_soft_reset && st_reg == ST_READY && o_cfg.por_restore &&
    !cmd_taken |=> o_cfg == CFG_DEFAULT) else $error("defaults not restored");
endmodule  // ata_feature_power_cmds

// ### core/pin_mode_store.sv
// pin-mode holder backed by nonvolatile storage
`timescale 1ns/1ns
module pin_mode_store (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // request from the command logic
  input wire logic i_start,
  input wire logic i_mode,
  output logic o_done,
  // nonvolatile storage side
  input wire logic i_nv_mode,
  input wire logic i_nv_ack,
  output logic o_nv_wr_req,
  output logic o_nv_wr_mode,
  // current mode
  output logic o_mode
);
  import ata_cmd_pkg::*;

  logic loaded_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
    end
  end

  // stored value is caught after reset release, never inside the reset branch
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_mode <= PIN_WP;
    end else if (!loaded_reg) begin
      o_mode <= i_nv_mode;
    end else if (o_nv_wr_req && i_nv_ack) begin
      o_mode <= o_nv_wr_mode;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_done <= 1'b0;
    if (i_srst) begin
      o_nv_wr_req <= 1'b0;
      o_nv_wr_mode <= PIN_WP;
    end else if (i_start) begin
      o_nv_wr_req <= 1'b1;
      o_nv_wr_mode <= i_mode;
    end else if (o_nv_wr_req && i_nv_ack) begin
      o_nv_wr_req <= 1'b0;
      o_done <= 1'b1;
    end
  end

  a_mode_held: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    loaded_reg && !(o_nv_wr_req && i_nv_ack) |=> $stable(o_mode)) else $error("pin mode changed without commit");
endmodule  // pin_mode_store

// ### core/power_timer.sv
// inactivity timer counting in 5 ms units, one pulse on expiry
`timescale 1ns/1ns
module power_timer #(
  parameter int TICK_CYCLES = ata_cmd_pkg::UNIT_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // control
  input wire logic i_restart,
  input wire logic [7:0] i_units,
  input wire logic i_run,
  // event
  output logic o_expire
);
  import ata_cmd_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0] pre_reg;
  logic [7:0] left_reg;
  logic armed_reg;

  // armed from reset with the default timeout, so sleep follows even with no idle command
  always_ff @(posedge i_ref_clk) begin
    o_expire <= 1'b0;
    if (i_srst) begin
      pre_reg <= '0;
      left_reg <= INACT_UNITS;
      armed_reg <= 1'b1;
    end else if (i_restart) begin
      pre_reg <= '0;
      left_reg <= i_units;
      armed_reg <= (i_units != 8'h00);
    end else if (armed_reg && i_run) begin
      if (pre_reg == TICK_LAST) begin
        pre_reg <= '0;
        left_reg <= left_reg - 8'h01;
        if (left_reg == 8'h01) begin
          armed_reg <= 1'b0;
          o_expire <= 1'b1;
        end
      end else begin
        pre_reg <= pre_reg + 1'b1;
      end
    end
  end

  a_expire_once: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_expire |=> !o_expire) else $error("timer expiry lasted more than one cycle");
endmodule  // power_timer

// ### test/nv_flush_model.sv
// model of the cache flush engine and the nonvolatile pin-mode cell
`timescale 1ns/1ns
module nv_flush_model #(
  parameter int DELAY = 4
) (
  // clock
  input wire logic i_ref_clk,
  // requests from the device
  input wire logic i_flush_req,
  input wire logic i_nv_wr_req,
  input wire logic i_nv_wr_mode,
  // answers
  output logic o_flush_done = 1'b0,
  output logic o_nv_ack = 1'b0,
  output logic o_nv_mode = 1'b0
);
  int fcnt = 0;
  int ncnt = 0;
  // cell keeps its value through i_srst, like real nonvolatile storage
  always @(posedge i_ref_clk) begin
    o_flush_done <= 1'b0;
    o_nv_ack <= 1'b0;
    fcnt <= (i_flush_req && !o_flush_done) ? fcnt + 1 : 0;
    ncnt <= (i_nv_wr_req && !o_nv_ack) ? ncnt + 1 : 0;
    if (fcnt == DELAY) begin
      o_flush_done <= 1'b1;
      fcnt <= 0;
    end
    if (ncnt == DELAY) begin
      o_nv_ack <= 1'b1;
      o_nv_mode <= i_nv_wr_mode;
      ncnt <= 0;
    end
  end
endmodule // nv_flush_model

// ### test/test_ata_feature_power_cmds.sv
// self-checking bench for the command block
`timescale 1ns/1ns
module test_ata_feature_power_cmds;
  import ata_cmd_pkg::*;
  localparam int TICK = 10;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_cmd_valid = 1'b0;
  taskfile_t i_tf = '0;
  logic i_soft_reset = 1'b0;
  logic i_drive_num = 1'b1;
  logic fdone, nack, nmode, freq, nreq, nwmode, o_busy, o_irq, o_abort, o_auto_pd_en, o_iocs16_en, o_pin_powerdown;
  logic fl, bz;
  pwr_t o_pwr_state;
  cfg_t o_cfg, e;
  int fails = 0;
  int total_checks = 0;
  int n;
  logic [7:0] ftab [17] = '{8'h01, 8'h81, 8'h02, 8'h82, 8'h82, 8'h05, 8'h85, 8'h09, 8'h89, 8'haa, 8'h55, 8'h66,
                            8'hcc, 8'h69, 8'h96, 8'h97, 8'h33};
  logic [7:0] xtab [7] = '{8'h01, 8'h0b, 8'h22, 8'h45, 8'h00, 8'h10, 8'h02};
  always #50 i_ref_clk = ~i_ref_clk;
  ata_feature_power_cmds #(.TICK_CYCLES(TICK)) u_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_cmd_valid(i_cmd_valid), .i_tf(i_tf), .i_soft_reset(i_soft_reset), .i_drive_num(i_drive_num),
    .i_flush_done(fdone), .o_flush_req(freq), .i_nv_mode(nmode), .i_nv_ack(nack), .o_nv_wr_req(nreq),
    .o_nv_wr_mode(nwmode), .o_busy(o_busy), .o_irq(o_irq), .o_abort(o_abort), .o_pwr_state(o_pwr_state),
    .o_auto_pd_en(o_auto_pd_en), .o_cfg(o_cfg), .o_iocs16_en(o_iocs16_en), .o_pin_powerdown(o_pin_powerdown));
  nv_flush_model u_mem (.i_ref_clk(i_ref_clk), .i_flush_req(freq), .i_nv_wr_req(nreq), .i_nv_wr_mode(nwmode),
    .o_flush_done(fdone), .o_nv_ack(nack), .o_nv_mode(nmode));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_cfg(input cfg_t got, input cfg_t exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t cfg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  // one command, bounded wait for completion
  task automatic run(input logic [7:0] op, input logic [7:0] ft, input logic [7:0] sc, input logic sig);
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_tf <= '{op, ft, sc, sig ? PIN_SIG_SEC_NUM : 8'h00, sig ? PIN_SIG_CYL_LOW : 8'h00,
              sig ? PIN_SIG_CYL_HIGH : 8'h00, {3'b101, i_drive_num, 4'h0}};
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    #1;
    fl = 1'b0;
    bz = 1'b0;
    for (n = 0; n < 300 && o_irq !== 1'b1; n++) begin
      wait_cyc(1);
      fl |= freq;
      bz |= o_busy;
    end
    chk_bit(o_irq, 1'b1);
    chk_bit(o_busy, 1'b0);
  endtask
  task automatic sf(input logic [7:0] f, input logic [7:0] sc);
    cfg_t t;
    logic ab;
    t = e;
    ab = 1'b0;
    case (f)
      FT_8BIT_ON: t.eight_bit = 1'b1;
      FT_8BIT_OFF: t.eight_bit = 1'b0;
      FT_WCACHE_ON: t.wcache = 1'b1;
      FT_WCACHE_OFF: t.wcache = 1'b0;
      FT_APM_ON: t.apm = 1'b1;
      FT_APM_OFF: t.apm = 1'b0;
      FT_EXT_ON: t.ext_pwr = 1'b1;
      FT_EXT_OFF: t.ext_pwr = 1'b0;
      FT_LA_ON: t.lookahead = 1'b1;
      FT_LA_OFF: t.lookahead = 1'b0;
      FT_POR_OFF: t.por_restore = 1'b0;
      FT_POR_ON: t.por_restore = 1'b1;
      FT_NOP_A, FT_NOP_B, FT_NOP_C: ;
      FT_XFER: case (sc[7:3])
        5'h00: if (sc[2:1] == 2'b00) {t.pio_flow, t.iordy_dis, t.pio_mode} = {1'b0, sc[0], 3'h0};
               else ab = 1'b1;
        5'h01: {t.pio_flow, t.iordy_dis, t.pio_mode} = {1'b1, 1'b0, sc[2:0]};
        5'h04: {t.dma_kind, t.dma_mode} = {DMA_MULTI, sc[2:0]};
        5'h08: {t.dma_kind, t.dma_mode} = {DMA_ULTRA, sc[2:0]};
        default: ab = 1'b1;
      endcase
      default: ab = 1'b1;
    endcase
    run(OP_SET_FEAT, f, sc, 1'b0);
    if (!ab) e = t;
    chk_bit(o_abort, ab);
    chk_bit(fl, f == FT_WCACHE_OFF);
    chk_cfg(o_cfg, e);
  endtask
  // idle command, then timer expiry must bring sleep
  task automatic pd(input logic [7:0] op, input logic [7:0] sc, input int u);
    run(op, 8'h00, sc, 1'b0);
    chk_bit(bz, 1'b1);
    chk_bit(o_pwr_state === PWR_IDLE, 1'b1);
    chk_bit(o_auto_pd_en, 1'b1);
    // look just short of expiry, so a timeout one unit short would show
    wait_cyc(u * TICK - 2);
    chk_bit(o_pwr_state === PWR_IDLE, 1'b1);
    wait_cyc(10);
    chk_bit(o_pwr_state === PWR_SLEEP, 1'b1);
  endtask
  task automatic hard_reset;
    @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    wait_cyc(3);
  endtask
  task automatic soft_reset;
    @(posedge i_ref_clk);
    i_soft_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_soft_reset <= 1'b0;
    wait_cyc(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    fails++;
    final_report();
  end
  initial begin
    hard_reset();
    e = CFG_DEFAULT;
    chk_cfg(o_cfg, e);
    chk_bit(o_iocs16_en, 1'b1);
    chk_bit(o_pin_powerdown, PIN_WP);
    chk_bit(o_auto_pd_en, 1'b1);
    $display("test reset done");
    foreach (ftab[i]) sf(ftab[i], 8'h00);
    sf(FT_8BIT_ON, 8'h00);
    chk_bit(o_iocs16_en, 1'b0);
    $display("test features done");
    foreach (xtab[i]) sf(FT_XFER, xtab[i]);
    $display("test transfer modes done");
    sf(FT_POR_OFF, 8'h00);
    sf(FT_WCACHE_ON, 8'h00);
    soft_reset();
    chk_cfg(o_cfg, e);
    sf(FT_POR_ON, 8'h00);
    soft_reset();
    e = CFG_DEFAULT;
    chk_cfg(o_cfg, e);
    $display("test soft reset done");
    pd(OP_IDLE_B, 8'h00, 3);
    pd(OP_IDLE_A, 8'h04, 4);
    run(OP_SLEEP_A, 8'h00, 8'h00, 1'b0);
    chk_bit(o_pwr_state === PWR_SLEEP, 1'b1);
    sf(FT_NOP_A, 8'h00);
    chk_bit(o_pwr_state === PWR_SLEEP, 1'b0);
    run(OP_SLEEP_B, 8'h00, 8'h00, 1'b0);
    chk_bit(o_pwr_state === PWR_SLEEP, 1'b1);
    $display("test power done");
    run(OP_PIN_MODE, PIN_FT_PD, PIN_SIG_SEC_CNT, 1'b1);
    chk_bit(o_abort, 1'b0);
    chk_bit(o_pin_powerdown, PIN_PD);
    run(OP_PIN_MODE, 8'h33, PIN_SIG_SEC_CNT, 1'b1);
    chk_bit(o_abort, 1'b1);
    run(OP_PIN_MODE, PIN_FT_WP, PIN_SIG_SEC_CNT, 1'b0);
    chk_bit(o_abort, 1'b1);
    chk_bit(o_pin_powerdown, PIN_PD);
    hard_reset();
    chk_bit(o_pin_powerdown, PIN_PD);
    run(OP_PIN_MODE, PIN_FT_WP, PIN_SIG_SEC_CNT, 1'b1);
    chk_bit(o_pin_powerdown, PIN_WP);
    $display("test pin mode done");
    final_report();
  end
endmodule // test_ata_feature_power_cmds
